/* File: hw/hsc_top.sv */
// halt standby controller: halt modes, release logic and apb registers
//
// Contract
// - halt instruction enters RUN, STOP or IDLE from mode field 00/01/10.
// - RUN halt stops only cpu execution; other blocks keep running.
// - IDLE halt keeps only the oscillator running.
// - STOP halt stops everything including the oscillator.
// - halt leaves only on external interrupt pin request or reset.
// - ext_irq_zero release below mask level resumes without servicing it.
// - micro dma start releases halt only when triggered by ext_irq_zero.
// - release by interrupt at or above mask starts its servicing.
// - unserviced release continues at instruction after the halt.
// - nmi and reset release eligibility ignore mask level.
// - reset releases every halt mode and initialises the device.
// - RUN halt keeps system clock; cpu issues dummy cycles until release.
// - RUN halt samples pending requests on clock output falling edge.
// - RUN halt: int1 to int5 release only when level at or above mask.
// - IDLE halt stops system clock, clock output pin held at 1.
// - IDLE halt detects requests without the system clock.
// - restart after release is synchronised to the clock.
// - IDLE halt released only by nmi, ext_irq_zero or reset; code also releases on micro dma start from ext_irq_zero.
// - STOP halt released only by reset, held low at least 3 ms.
// - STOP with drive bit: pins hold; without: bus floats; reset clears bit.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module hsc_top (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu and interrupt controller side
  input wire logic halt_instr,
  input wire logic [2:0] interrupt_mask_level,
  input wire logic [2:0] ext_irq_zero_level,
  input wire logic [14:0] ext_irq_one_to_five_level,
  input wire logic dma_req,
  input wire logic dma_from_ext_irq_zero,
  // external interrupt pins
  input wire logic nmi_n_pin,
  input wire logic ext_irq_zero,
  input wire logic [4:0] ext_irq_one_to_five,
  // clock output pin
  output logic clk_pin,
  output logic clk_pin_oe,
  // power controls and resume indications
  output hsc_pkg::hsc_pwr_t pwr,
  output logic dummy_cycle,
  output logic resume_service,
  output logic resume_next,
  output logic [2:0] resume_src,
  output logic rd_psram_mode,
  output logic sys_clk_out_off
);
  hsc_pkg::hsc_state_t state;
  hsc_pkg::hsc_state_t next_state;
  hsc_pkg::hsc_irq_t irq_s;
  hsc_pkg::hsc_pwr_t next_pwr;
  logic [7:0] standby_control_reg;
  logic [1:0] halt_mode_select;
  logic drve;
  logic clk_int;
  logic clk_run;
  logic clk_fall;
  logic next_clk_int;
  logic nmi_prev;
  logic nmi_hit;
  logic rel;
  logic rel_svc;
  logic [2:0] rel_src;
  logic svc_q;
  logic [2:0] src_q;
  logic wr_acc;
  logic rd_setup;
  logic addr_ok;
  logic [7:0] status_val;
  logic [4:0] irq15_ok;

  assign halt_mode_select = standby_control_reg[hsc_pkg::HM_LSB +: 2];
  assign drve = standby_control_reg[hsc_pkg::DRVE_BIT];

  // pin synchronisers; nmi pin idles high
  hsc_sync #(
    .W(7),
    .INIT(7'h40)
  ) u_pin_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({nmi_n_pin, ext_irq_zero, ext_irq_one_to_five}),
    .q(irq_s)
  );

  // nmi is taken on its falling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_prev <= 1'b1;
    end else begin
      nmi_prev <= irq_s.nmi_n;
    end
  end
  assign nmi_hit = nmi_prev & ~irq_s.nmi_n;

  // apb decode
  assign addr_ok = (paddr == hsc_pkg::STBY_ADDR) || (paddr == hsc_pkg::STAT_ADDR);
  assign wr_acc = psel & penable & pready & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;

  // status value shows controller state and the last release
  always_comb begin
    status_val = 8'h00;
    status_val[hsc_pkg::ST_STATE_LSB +: 3] = state;
    status_val[hsc_pkg::ST_SVC_BIT] = svc_q;
    status_val[hsc_pkg::ST_SRC_LSB +: 3] = src_q;
    status_val[hsc_pkg::ST_HALT_BIT] = (state != hsc_pkg::HSC_EXEC);
  end

  // apb answer: one wait-free access phase after each setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= hsc_pkg::RDATA_ZERO;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      if (rd_setup && paddr == hsc_pkg::STBY_ADDR) begin
        prdata <= {24'h000000, standby_control_reg & hsc_pkg::STBY_RMASK};
      end else if (rd_setup && paddr == hsc_pkg::STAT_ADDR) begin
        prdata <= {24'h000000, status_val};
      end else begin
        prdata <= hsc_pkg::RDATA_ZERO;
      end
    end
  end

  // standby control register; reset clears the drive bit too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby_control_reg <= hsc_pkg::STBY_RESET;
    end else if (wr_acc && paddr == hsc_pkg::STBY_ADDR) begin
      standby_control_reg <= pwdata[7:0] & hsc_pkg::STBY_WMASK;
    end
  end

  // pin control bits leave as flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_psram_mode <= 1'b0;
      sys_clk_out_off <= 1'b0;
    end else begin
      rd_psram_mode <= standby_control_reg[hsc_pkg::RDE_BIT];
      sys_clk_out_off <= standby_control_reg[hsc_pkg::SCOUT_OFF_BIT];
    end
  end

  // internal clock phase; it halts high in idle and stop
  assign clk_run = (state != hsc_pkg::HSC_IDLE) && (state != hsc_pkg::HSC_STOP);
  assign clk_fall = clk_run & clk_int;
  assign next_clk_int = clk_run ? ~clk_int : 1'b1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_int <= 1'b1;
    end else begin
      clk_int <= next_clk_int;
    end
  end

  // clock output pin: high from the very edge that enters idle or stop, so the pin
  // never shows a last low phase while the power controls already say halted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_pin <= 1'b1;
      clk_pin_oe <= 1'b1;
    end else begin
      clk_pin <= next_clk_int | !next_pwr.sys_clk_en |
        standby_control_reg[hsc_pkg::CLK_OFF_BIT];
      clk_pin_oe <= !(next_state == hsc_pkg::HSC_STOP && !drve);
    end
  end

  // int1 to int5 eligible only at or above the mask level
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      irq15_ok[i] = irq_s.irq15[i] &&
        (ext_irq_one_to_five_level[3*i +: 3] >= interrupt_mask_level);
    end
  end

  // release decision per halt mode and source
  always_comb begin
    rel = 1'b0;
    rel_svc = 1'b0;
    rel_src = hsc_pkg::SRC_NMI;
    case (state)
      hsc_pkg::HSC_RUN: begin
        if (clk_fall) begin
          if (nmi_hit) begin
            rel = 1'b1;
            rel_svc = 1'b1;
            rel_src = hsc_pkg::SRC_NMI;
          end else if (irq_s.irq0) begin
            rel = 1'b1;
            rel_svc = (ext_irq_zero_level >= interrupt_mask_level);
            rel_src = hsc_pkg::SRC_EXT_IRQ_ZERO;
          end else if (dma_req && dma_from_ext_irq_zero) begin
            rel = 1'b1;
            rel_svc = 1'b0;
            rel_src = hsc_pkg::SRC_DMA0;
          end else begin
            for (int i = 4; i >= 0; i--) begin
              if (irq15_ok[i]) begin
                rel = 1'b1;
                rel_svc = 1'b1;
                rel_src = hsc_pkg::SRC_INT1 + 3'(i);
              end
            end
          end
        end
      end
      hsc_pkg::HSC_IDLE: begin
        // no clock edge needed: detection runs every oscillator cycle
        if (nmi_hit) begin
          rel = 1'b1;
          rel_svc = 1'b1;
          rel_src = hsc_pkg::SRC_NMI;
        end else if (irq_s.irq0) begin
          rel = 1'b1;
          rel_svc = (ext_irq_zero_level >= interrupt_mask_level);
          rel_src = hsc_pkg::SRC_EXT_IRQ_ZERO;
        end else if (dma_req && dma_from_ext_irq_zero) begin
          rel = 1'b1;
          rel_svc = 1'b0;
          rel_src = hsc_pkg::SRC_DMA0;
        end
      end
      default: begin
        // stop, exec and wake: nothing releases here except reset
        rel = 1'b0;
      end
    endcase
  end

  // state sequence
  always_comb begin
    next_state = state;
    case (state)
      hsc_pkg::HSC_EXEC: begin
        if (halt_instr) begin
          case (halt_mode_select)
            hsc_pkg::HM_STOP: next_state = hsc_pkg::HSC_STOP;
            hsc_pkg::HM_IDLE: next_state = hsc_pkg::HSC_IDLE;
            default: next_state = hsc_pkg::HSC_RUN;
          endcase
        end
      end
      hsc_pkg::HSC_RUN: begin
        if (rel) begin
          next_state = hsc_pkg::HSC_WAKE;
        end
      end
      hsc_pkg::HSC_IDLE: begin
        if (rel) begin
          next_state = hsc_pkg::HSC_WAKE;
        end
      end
      hsc_pkg::HSC_STOP: begin
        next_state = hsc_pkg::HSC_STOP;
      end
      hsc_pkg::HSC_WAKE: begin
        if (clk_fall) begin
          next_state = hsc_pkg::HSC_EXEC;
        end
      end
      default: begin
        next_state = hsc_pkg::HSC_EXEC;
      end
    endcase
  end

  // state register; asynchronous reset leaves any halt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= hsc_pkg::HSC_EXEC;
    end else begin
      state <= next_state;
    end
  end

  // remember how the halt was released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      svc_q <= 1'b0;
      src_q <= hsc_pkg::SRC_NMI;
    end else if (rel) begin
      svc_q <= rel_svc;
      src_q <= rel_src;
    end
  end

  // resume pulses on the clock falling phase that ends the wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resume_service <= 1'b0;
      resume_next <= 1'b0;
      resume_src <= hsc_pkg::SRC_NMI;
    end else begin
      resume_service <= (state == hsc_pkg::HSC_WAKE) && clk_fall && svc_q;
      resume_next <= (state == hsc_pkg::HSC_WAKE) && clk_fall && !svc_q;
      if (state == hsc_pkg::HSC_WAKE && clk_fall) begin
        resume_src <= src_q;
      end
    end
  end

  // power controls follow the coming state
  always_comb begin
    next_pwr.cpu_stall = (next_state != hsc_pkg::HSC_EXEC);
    next_pwr.sys_clk_en = (next_state != hsc_pkg::HSC_IDLE) &&
      (next_state != hsc_pkg::HSC_STOP);
    next_pwr.osc_en = (next_state != hsc_pkg::HSC_STOP);
    next_pwr.bus_float = (next_state == hsc_pkg::HSC_STOP) && !drve;
    next_pwr.pin_hold = (next_state == hsc_pkg::HSC_STOP) && drve;
  end

  // registered power controls and dummy cycle marker
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr <= '{cpu_stall: 1'b0, sys_clk_en: 1'b1, osc_en: 1'b1,
        bus_float: 1'b0, pin_hold: 1'b0};
      dummy_cycle <= 1'b0;
    end else begin
      pwr <= next_pwr;
      dummy_cycle <= (next_state == hsc_pkg::HSC_RUN);
    end
  end
endmodule

/* File: hw/hsc_pkg.sv */
// package of constants and carriers for the halt standby controller
package hsc_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] STBY_IDX = 8'h1E;
  localparam logic [7:0] STAT_IDX = 8'h1F;
  localparam logic [7:0] STBY_ADDR = {STBY_IDX[5:0], 2'b00};
  localparam logic [7:0] STAT_ADDR = {STAT_IDX[5:0], 2'b00};
  // standby control register fields
  localparam int RDE_BIT = 7;
  localparam int SCOUT_OFF_BIT = 5;
  localparam int CLK_OFF_BIT = 4;
  localparam int HM_LSB = 2;
  localparam int DRVE_BIT = 0;
  localparam logic [7:0] STBY_RESET = 8'h00;
  localparam logic [7:0] STBY_WMASK = 8'hBD;
  localparam logic [7:0] STBY_RMASK = 8'h3D;
  // halt mode encodings
  localparam logic [1:0] HM_RUN = 2'b00;
  localparam logic [1:0] HM_STOP = 2'b01;
  localparam logic [1:0] HM_IDLE = 2'b10;
  // status register fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_SVC_BIT = 3;
  localparam int ST_SRC_LSB = 4;
  localparam int ST_HALT_BIT = 7;
  // release source codes
  localparam logic [2:0] SRC_NMI = 3'h0;
  localparam logic [2:0] SRC_EXT_IRQ_ZERO = 3'h1;
  localparam logic [2:0] SRC_INT1 = 3'h2;
  localparam logic [2:0] SRC_DMA0 = 3'h7;
  // timing: reset low time the outside must give to leave stop
  localparam int CLK_HZ = 10000000;
  localparam int RST_HOLD_MS = 3;
  localparam int RST_HOLD_CYC = RST_HOLD_MS * (CLK_HZ / 1000);
  // apb answers
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
  // controller states
  typedef enum logic [2:0] {
    HSC_EXEC,
    HSC_RUN,
    HSC_IDLE,
    HSC_STOP,
    HSC_WAKE
  } hsc_state_t;
  // power and pin controls driven to the rest of the chip
  typedef struct packed {
    logic cpu_stall;
    logic sys_clk_en;
    logic osc_en;
    logic bus_float;
    logic pin_hold;
  } hsc_pwr_t;
  // external interrupt pins after synchronisation
  typedef struct packed {
    logic nmi_n;
    logic irq0;
    logic [4:0] irq15;
  } hsc_irq_t;
endpackage

/* File: hw/hsc_sync.sv */
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module hsc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // async in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

/* File: bench/hsc_irq_src.sv */
// partner model: external interrupt pins and the reset input
`timescale 1ns/1ps
module hsc_irq_src #(
  parameter int HOLD = hsc_pkg::RST_HOLD_CYC
) (
  // clock and requests from the bench
  input wire logic pclk,
  input wire logic rst_req,
  input wire logic nmi_req,
  input wire logic irq0_req,
  input wire logic [4:0] irq15_req,
  // pins into the controller
  output logic presetn,
  output logic nmi_n_pin,
  output logic ext_irq_zero,
  output logic [4:0] ext_irq_one_to_five
);
  int cnt = 3;
  // once asked, reset stays low for the whole hold time
  always @(posedge pclk) begin
    if (rst_req) cnt <= HOLD;
    else if (cnt != 0) cnt <= cnt - 1;
  end
  assign presetn = (cnt == 0) && !rst_req;
  // pins are plain levels, nmi is low while requested
  assign nmi_n_pin = !nmi_req;
  assign ext_irq_zero = irq0_req;
  assign ext_irq_one_to_five = irq15_req;
endmodule

/* File: bench/hsc_top_assertions.sv */
// concurrent checks on the halt standby controller ports
`timescale 1ns/1ps
module hsc_top_assertions (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // halt side
  input wire logic halt_instr,
  input wire logic clk_pin,
  input wire logic clk_pin_oe,
  input wire hsc_pkg::hsc_pwr_t pwr,
  input wire logic dummy_cycle,
  input wire logic resume_service,
  input wire logic resume_next
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb answers in the cycle after setup
  access_ready_a: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  err_pair_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // halt entry and the clocks in each halt state
  halt_enter_a: assert property (halt_instr && !pwr.cpu_stall |=> pwr.cpu_stall)
    else $error("halt not taken");
  run_clock_a: assert property (dummy_cycle |-> pwr.sys_clk_en && pwr.cpu_stall)
    else $error("run halt clock stopped");
  idle_pin_a: assert property (pwr.cpu_stall && pwr.osc_en && !pwr.sys_clk_en |-> clk_pin)
    else $error("clock pin not high in idle");
  stop_all_a: assert property (!pwr.osc_en |-> pwr.cpu_stall && !pwr.sys_clk_en)
    else $error("stop leaves circuits running");
  stop_stay_a: assert property (!pwr.osc_en |=> !pwr.osc_en && !resume_service)
    else $error("stop left without reset");
  stop_pins_a: assert property (!pwr.osc_en |-> clk_pin_oe != pwr.bus_float)
    else $error("stop pin drive wrong");
  // resume pulses
  resume_one_a: assert property (resume_service |-> !resume_next ##1 !resume_service)
    else $error("resume pulse malformed");
  resume_sync_a: assert property (resume_service || resume_next |-> $fell(pwr.cpu_stall))
    else $error("resume not with stall drop");
  halt_exit_a: assert property ($fell(pwr.cpu_stall) |-> resume_service || resume_next)
    else $error("halt left without source");
  // main scenarios reached
  svc_c: cover property (resume_service);
  next_c: cover property (resume_next);
  stop_c: cover property (!pwr.osc_en);
endmodule
bind hsc_top hsc_top_assertions i_hsc_top_assertions (.pclk, .presetn, .psel, .penable,
  .pready, .pslverr, .halt_instr, .clk_pin, .clk_pin_oe, .pwr, .dummy_cycle,
  .resume_service, .resume_next);

/* File: bench/hsc_top_tb_top.sv */
// self-checking bench for the halt standby controller
`timescale 1ns/1ps
module hsc_top_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic halt_instr, dma_req, dma_from_ext_irq_zero, nmi_n_pin, ext_irq_zero;
  logic [2:0] interrupt_mask_level, ext_irq_zero_level, resume_src;
  logic [14:0] ext_irq_one_to_five_level;
  logic [4:0] ext_irq_one_to_five, irq15_req;
  logic clk_pin, clk_pin_oe, dummy_cycle, resume_service, resume_next;
  logic rd_psram_mode, sys_clk_out_off, rst_req, nmi_req, irq0_req;
  hsc_pkg::hsc_pwr_t pwr;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  hsc_top i_hsc_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .halt_instr, .interrupt_mask_level, .ext_irq_zero_level,
    .ext_irq_one_to_five_level, .dma_req, .dma_from_ext_irq_zero, .nmi_n_pin, .ext_irq_zero,
    .ext_irq_one_to_five, .clk_pin, .clk_pin_oe, .pwr, .dummy_cycle, .resume_service,
    .resume_next, .resume_src, .rd_psram_mode, .sys_clk_out_off);
  hsc_irq_src i_hsc_irq_src (.pclk, .rst_req, .nmi_req, .irq0_req, .irq15_req, .presetn,
    .nmi_n_pin, .ext_irq_zero, .ext_irq_one_to_five);
  // clock
  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 70000) begin
      n_fail++;
      $display("Error %0t: timeout", $time);
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  // set the mode field and issue the halt instruction
  task automatic halt(input logic [1:0] m, input logic drv);
    apb(1'h1, hsc_pkg::STBY_ADDR, (32'(m) << hsc_pkg::HM_LSB) | 32'(drv));
    halt_instr <= 1'h1;
    @(posedge pclk);
    halt_instr <= 1'h0;
    @(posedge pclk);
    chk(pwr.cpu_stall, 1'h1);
  endtask
  task automatic wait_res(input logic svc, input logic [2:0] src);
    for (int i = 0; i < 40; i++) begin
      @(posedge pclk);
      if (resume_service === 1'h1 || resume_next === 1'h1) break;
    end
    chk({resume_service, resume_next, resume_src}, {svc, !svc, src});
    chk(pwr.cpu_stall, 1'h0);
  endtask
  task automatic no_rel(input int n);
    repeat (n) begin
      @(posedge pclk);
      chk(resume_service | resume_next, 1'h0);
    end
  endtask
  task automatic t_regs();
    apb(1'h0, hsc_pkg::STBY_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'h1, hsc_pkg::STBY_ADDR, 32'hFF);
    apb(1'h0, hsc_pkg::STBY_ADDR, 32'h0);
    chk(rd, 32'h3D);
    chk({rd_psram_mode, sys_clk_out_off, clk_pin}, 3'h7);
    apb(1'h0, 8'h40, 32'h0);
    chk({err, rd}, {1'h1, 32'h0});
  endtask
  task automatic t_run_ext_irq_zero(input logic [2:0] lvl, input logic svc);
    ext_irq_zero_level <= lvl;
    halt(hsc_pkg::HM_RUN, 1'h0);
    chk({dummy_cycle, pwr.sys_clk_en, pwr.osc_en}, 3'h7);
    irq0_req <= 1'h1;
    wait_res(svc, hsc_pkg::SRC_EXT_IRQ_ZERO);
    irq0_req <= 1'h0;
  endtask
  task automatic t_int1();
    interrupt_mask_level <= 3'h5;
    ext_irq_one_to_five_level <= 15'h0002;
    halt(hsc_pkg::HM_RUN, 1'h0);
    irq15_req <= 5'h01;
    no_rel(20);
    interrupt_mask_level <= 3'h1;
    wait_res(1'h1, hsc_pkg::SRC_INT1);
    irq15_req <= 5'h00;
  endtask
  task automatic t_dma();
    halt(2'h3, 1'h0);
    chk(dummy_cycle, 1'h1);
    dma_req <= 1'h1;
    no_rel(15);
    dma_from_ext_irq_zero <= 1'h1;
    wait_res(1'h0, hsc_pkg::SRC_DMA0);
    dma_req <= 1'h0;
    dma_from_ext_irq_zero <= 1'h0;
  endtask
  task automatic t_idle();
    interrupt_mask_level <= 3'h7;
    halt(hsc_pkg::HM_IDLE, 1'h0);
    chk({pwr.sys_clk_en, pwr.osc_en, clk_pin}, 3'h3);
    irq15_req <= 5'h1F;
    no_rel(20);
    nmi_req <= 1'h1;
    wait_res(1'h1, hsc_pkg::SRC_NMI);
    nmi_req <= 1'h0;
    irq15_req <= 5'h00;
  endtask
  task automatic t_stop(input logic drv);
    halt(hsc_pkg::HM_STOP, drv);
    chk({pwr.osc_en, clk_pin_oe, pwr.bus_float, pwr.pin_hold}, {1'h0, drv, !drv, drv});
    nmi_req <= 1'h1;
    irq0_req <= 1'h1;
    no_rel(20);
    nmi_req <= 1'h0;
    irq0_req <= 1'h0;
    rst_req <= 1'h1;
    @(posedge pclk);
    rst_req <= 1'h0;
    for (int i = 0; i < 35000; i++) begin
      @(posedge pclk);
      if (presetn === 1'h1) break;
    end
    chk(presetn, 1'h1);
    chk(pwr.cpu_stall, 1'h0);
    apb(1'h0, hsc_pkg::STBY_ADDR, 32'h0);
    chk(rd, 32'h0);
  endtask
  // main sequence
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    halt_instr = 1'h0;
    interrupt_mask_level = 3'h3;
    ext_irq_zero_level = 3'h5;
    ext_irq_one_to_five_level = 15'h0;
    dma_req = 1'h0;
    dma_from_ext_irq_zero = 1'h0;
    rst_req = 1'h0;
    nmi_req = 1'h0;
    irq0_req = 1'h0;
    irq15_req = 5'h00;
    while (presetn !== 1'h1) @(posedge pclk);
    t_regs();
    t_run_ext_irq_zero(3'h5, 1'h1);
    interrupt_mask_level <= 3'h6;
    t_run_ext_irq_zero(3'h2, 1'h0);
    t_int1();
    t_dma();
    t_idle();
    t_stop(1'h1);
    t_stop(1'h0);
    report_and_stop();
  end
endmodule
